/* File: rtl/at_bridge_pkg.sv */
/*
  shared constants and types for the processor-to-expansion-bus cycle bridge.
  assumes both ends run on ref_clk at 25 MHz with synchronous reset.
*/
package at_bridge_pkg;
  localparam int unsigned REF_CLK_MHZ      = 25;
  // AT clock divider codes: divisor per select code, code 0 is the fixed clock
  localparam logic [2:0]  AT_CLK_FIXED     = 3'h0;
  localparam logic [3:0]  FIXED_DIV        = 4'h4;
  localparam logic [1:0]  WS16_SLOW        = 2'h2;
  localparam logic [1:0]  WS16_FAST        = 2'h1;
  localparam logic [2:0]  WS8_SLOW         = 3'h5;
  localparam logic [2:0]  WS8_FAST         = 3'h4;
  localparam logic [7:0]  LOW_MEM_TOP      = 8'h10;
  localparam int unsigned ADDR_W           = 32;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOCAL = 3'h1,
    ST_CMD   = 3'h3,
    ST_WAIT  = 3'h7,
    ST_DONE  = 3'h5,
    ST_HOLD  = 3'h4
  } cyc_state_t;

  typedef struct packed {
    logic is_mem;
    logic is_write;
    logic is_data;
  } cyc_type_t;

  function automatic cyc_type_t decode_cycle(input logic m_io, input logic w_r,
                                             input logic d_c);
    cyc_type_t t;
    t.is_mem   = m_io;
    t.is_write = w_r;
    t.is_data  = d_c;
    return t;
  endfunction

  function automatic logic [3:0] clk_divisor(input logic [2:0] sel);
    logic [3:0] d;
    d = FIXED_DIV;
    case (sel)
      3'h1: d = 4'hA;
      3'h2: d = 4'h8;
      3'h3: d = 4'h6;
      3'h4: d = 4'h5;
      3'h5: d = 4'h4;
      3'h6: d = 4'h3;
      3'h7: d = 4'h2;
      default: d = FIXED_DIV;
    endcase
    return d;
  endfunction
endpackage

/* File: rtl/at_bridge_if.sv */
/*
  signals between the processor side and the bridge.
  assumes the bench resolves nothing: all pins here are one-directional
  except the address bus, which carries separate in/out/enable signals.
*/
`timescale 1ns/1ps
interface at_bridge_if;
  logic        addr_strobe_n;
  logic        m_io;
  logic        w_r;
  logic        d_c;
  logic [3:0]  byte_enables_n;
  logic [31:0] addr_from_proc;
  logic [31:0] addr_to_proc;
  logic        addr_to_proc_oe;
  logic        proc_ready_n;
  logic        hold_req;
  logic        hold_ack;
  logic        nmi;
  logic        proc_irq;
  logic        addr20_mask_n;
  logic        proc_cache_en_n;
  logic        fp_error_n;
  logic        ignore_num_err_n;
  logic        burst_last_n;
  logic        burst_ready_n;
  logic        proc_error_out_n;
  logic        proc_busy_out_n;
  logic        proc_request_out;
  logic        proc_reset;

  modport bridge (
    input  addr_strobe_n, m_io, w_r, d_c, byte_enables_n, addr_from_proc,
    input  hold_ack, fp_error_n, burst_last_n,
    output addr_to_proc, addr_to_proc_oe, proc_ready_n, hold_req, nmi, proc_irq,
    output addr20_mask_n, proc_cache_en_n, ignore_num_err_n, burst_ready_n,
    output proc_error_out_n, proc_busy_out_n, proc_request_out, proc_reset
  );
  modport proc (
    output addr_strobe_n, m_io, w_r, d_c, byte_enables_n, addr_from_proc,
    output hold_ack, fp_error_n, burst_last_n,
    input  addr_to_proc, addr_to_proc_oe, proc_ready_n, hold_req, nmi, proc_irq,
    input  addr20_mask_n, proc_cache_en_n, ignore_num_err_n, burst_ready_n,
    input  proc_error_out_n, proc_busy_out_n, proc_request_out, proc_reset
  );
endinterface

/* File: rtl/at_clk_gen.sv */
/*
  divides ref_clk to make the expansion bus clock and a one-cycle tick at
  each rising edge of it. assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
module at_clk_gen
  import at_bridge_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] at_clk_select,
  output logic            at_bus_clk,
  output logic            at_tick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       clk;
    logic       tick;
  } gen_t;

  gen_t st_ff;
  gen_t nxt_st;
  logic [3:0] div;

  always_comb begin
    div = clk_divisor(at_clk_select); // RL23
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= div - 4'h1) begin
      nxt_st.cnt  = 4'h0;
      nxt_st.clk  = 1'b1;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
      if (st_ff.cnt + 4'h1 >= {1'b0, div[3:1]}) begin
        nxt_st.clk = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign at_bus_clk = st_ff.clk;
  assign at_tick    = st_ff.tick;
endmodule

/* File: rtl/at_bridge_dev.sv */
/*
  bridge end: processor cycle decode and termination, hold handshake,
  interrupt and coprocessor signalling, and expansion bus command timing.
  assumes the processor-side pins arrive through at_bridge_if; bus pins and
  asynchronous inputs pass two flip-flops before use.
*/
// Functional notes
// [RL1] processor strobe starts every cycle
// [RL2] cycle type from three definition inputs
// [RL3] ready low when cycle completes
// [RL4] hold request answered by held acknowledge
// [RL5] non-maskable interrupt output active high
// [RL6] irq output high while request pending
// [RL7] a20 mask high in reset, forces low
// [RL8] cache enable low on cacheable cycles; in alt_mode it stays high, or follows coprocessor error during reset
// [RL9] error input; ignore-error output provided
// [RL10] burst last ends burst at ready; the bridge ignores burst_last_n, burst_ready_n copies ready outside alt_mode and stays high in alt_mode
// [RL11] error out follows coprocessor during reset
// [RL12] busy and request pass through
// [RL13] local device claims, then signals ready
// [RL14] byte enables map to low address bits
// [RL15] drive address lines while processor held
// [RL16] bit0 output, low in wide dma
// [RL17] low-memory commands below 1MB only
// [RL18] commands output, input in master cycles
// [RL19] wide select sizes the cycle
// [RL20] zero-wait ends cycle at once
// [RL21] channel ready low inserts wait states
// [RL22] master takeover floats address and control
// [RL23] three-bit select picks bus clock
// [RL24] config bits select wait states
`timescale 1ns/1ps
module at_bridge_dev
  import at_bridge_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  at_bridge_if.bridge     pif,
  input  wire logic [2:0] at_clk_select,
  input  wire logic       ws16_fast,
  input  wire logic       ws8_fast,
  input  wire logic       alt_mode,
  input  wire logic       nmi_req,
  input  wire logic       irq_pending,
  input  wire logic       a20_gate,
  input  wire logic       cacheable,
  input  wire logic       bus_hold_req,
  input  wire logic       dma_cycle,
  input  wire logic       dma_wide,
  input  wire logic [31:0] hold_addr,
  input  wire logic       copro_error_n,
  input  wire logic       copro_busy_n,
  input  wire logic       copro_request,
  input  wire logic       local_dev_cycle_n,
  input  wire logic       local_dev_ready_n,
  input  wire logic       mem_wide_sel_n,
  input  wire logic       io_wide_sel_n,
  input  wire logic       zero_wait_n,
  input  wire logic       channel_ready,
  input  wire logic       master_n,
  input  wire logic       at_addr_bit0_in,
  output logic            at_bus_clk,
  output logic            at_addr_bit0,
  output logic            at_addr_bit1,
  output logic            high_byte_en_n,
  output logic            at_addr_oe,
  output logic            at_mem_read_n,
  output logic            at_mem_write_n,
  output logic            low_mem_read_n,
  output logic            low_mem_write_n,
  output logic            at_io_read_n,
  output logic            at_io_write_n,
  output logic            at_cmd_oe,
  output logic            copro_present
);
  localparam int unsigned N_SYNC = 11;

  typedef struct packed {
    logic [N_SYNC-1:0] s1;
    logic [N_SYNC-1:0] s2;
    cyc_state_t        state;
    cyc_type_t         cyc;
    logic              wide;
    logic              low_mem;
    logic [2:0]        ws_left;
    logic              rdy_n;
    logic              cmd_on;
    logic              ken_n;
    logic [1:0]        sa;
    logic              bhe_n;
    logic              in_reset;
    logic              copro_seen;
    logic              err_n;
  } dev_t;

  dev_t st_ff;
  dev_t nxt_st;
  logic at_tick;
  logic [N_SYNC-1:0] raw;
  logic ldc_n;
  logic ldr_n;
  logic mws_n;
  logic iws_n;
  logic zw_n;
  logic chrdy;
  logic mst_n;
  logic cpe_n;
  logic bz_n;
  logic prq;
  logic a0_in;

  at_clk_gen u_clk (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .at_clk_select(at_clk_select),
    .at_bus_clk   (at_bus_clk),
    .at_tick      (at_tick)
  );

  assign raw = {at_addr_bit0_in, copro_request, copro_busy_n, copro_error_n, master_n,
                channel_ready, zero_wait_n, io_wide_sel_n, mem_wide_sel_n,
                local_dev_ready_n, local_dev_cycle_n};
  assign {a0_in, prq, bz_n, cpe_n, mst_n, chrdy, zw_n, iws_n, mws_n, ldr_n,
          ldc_n} = st_ff.s2;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.rdy_n = 1'b1;
    nxt_st.in_reset = 1'b0;
    nxt_st.err_n = 1'b1; // RL11
    if (st_ff.in_reset) begin
      nxt_st.copro_seen = !cpe_n; // RL11
    end
    case (st_ff.state)
      ST_IDLE: begin
        if (bus_hold_req) begin
          nxt_st.state = ST_HOLD;
        end else if (!pif.addr_strobe_n) begin // RL1
          nxt_st.cyc = decode_cycle(pif.m_io, pif.w_r, pif.d_c); // RL2
          nxt_st.ken_n = !(pif.m_io && cacheable); // RL8
          nxt_st.low_mem = pif.addr_from_proc[31:20] == '0; // RL17
          nxt_st.sa[1] = pif.byte_enables_n[1:0] == 2'h3; // RL14
          nxt_st.sa[0] = pif.byte_enables_n[0] &
                         (pif.byte_enables_n[2] | !pif.byte_enables_n[1]);
          nxt_st.bhe_n = pif.byte_enables_n[1] & pif.byte_enables_n[3];
          nxt_st.state = ST_LOCAL;
        end
      end
      ST_LOCAL: begin
        if (!ldc_n) begin // RL13
          if (!ldr_n) begin
            nxt_st.rdy_n = 1'b0;
            nxt_st.state = ST_DONE;
          end
        end else if (at_tick) begin
          nxt_st.wide = st_ff.cyc.is_mem ? !mws_n : !iws_n; // RL19
          nxt_st.ws_left = !(st_ff.cyc.is_mem ? !mws_n : !iws_n)
                           ? (ws8_fast ? WS8_FAST : WS8_SLOW)
                           : {1'b0, ws16_fast ? WS16_FAST : WS16_SLOW}; // RL24
          nxt_st.cmd_on = 1'b1;
          nxt_st.state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (!zw_n) begin // RL20
          nxt_st.cmd_on = 1'b0;
          nxt_st.rdy_n = 1'b0;
          nxt_st.state = ST_DONE;
        end else if (at_tick) begin
          if (st_ff.ws_left != 3'h0) begin
            nxt_st.ws_left = st_ff.ws_left - 3'h1;
          end else begin
            nxt_st.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (!zw_n || (chrdy && at_tick)) begin // RL21
          nxt_st.cmd_on = 1'b0;
          nxt_st.rdy_n = 1'b0; // RL3
          nxt_st.state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_st.ken_n = 1'b1;
        nxt_st.state = ST_IDLE;
      end
      ST_HOLD: begin
        if (!bus_hold_req) begin
          nxt_st.state = ST_IDLE;
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      // synchronisers keep sampling so the coprocessor level is valid at release
      st_ff.s1 <= raw;
      st_ff.s2 <= st_ff.s1;
      st_ff.state <= ST_IDLE;
      st_ff.rdy_n <= 1'b1;
      st_ff.ken_n <= 1'b1;
      st_ff.bhe_n <= 1'b1;
      st_ff.in_reset <= 1'b1;
      st_ff.err_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // processor side
  assign pif.proc_ready_n     = st_ff.rdy_n; // RL3
  assign pif.hold_req         = st_ff.state == ST_HOLD; // RL4
  assign pif.addr_to_proc     = hold_addr;
  assign pif.addr_to_proc_oe  = pif.hold_req && pif.hold_ack; // RL15
  assign pif.nmi              = nmi_req; // RL5
  assign pif.proc_irq         = irq_pending; // RL6
  assign pif.addr20_mask_n    = st_ff.in_reset | a20_gate; // RL7
  assign pif.proc_cache_en_n  = alt_mode ? (st_ff.in_reset ? cpe_n : 1'b1) : st_ff.ken_n; // RL8
  assign pif.ignore_num_err_n = alt_mode ? !prq : pif.fp_error_n; // RL9
  assign pif.burst_ready_n    = alt_mode ? 1'b1 : st_ff.rdy_n; // RL10
  assign pif.proc_error_out_n = st_ff.in_reset ? cpe_n : 1'b1; // RL11
  assign pif.proc_busy_out_n  = alt_mode ? bz_n : 1'b1; // RL12
  assign pif.proc_request_out = alt_mode & prq; // RL12
  assign pif.proc_reset       = st_ff.in_reset;
  assign copro_present        = st_ff.copro_seen;

  // expansion bus side
  assign at_addr_oe      = mst_n; // RL22
  assign at_cmd_oe       = mst_n; // RL18
  assign at_addr_bit0    = !mst_n ? a0_in : // RL16
                           (dma_cycle && dma_wide) ? 1'b0 : st_ff.sa[0];
  assign at_addr_bit1    = st_ff.sa[1];
  assign high_byte_en_n  = st_ff.bhe_n;
  assign at_mem_read_n   = !(st_ff.cmd_on && st_ff.cyc.is_mem && !st_ff.cyc.is_write);
  assign at_mem_write_n  = !(st_ff.cmd_on && st_ff.cyc.is_mem && st_ff.cyc.is_write);
  assign low_mem_read_n  = at_mem_read_n | !st_ff.low_mem; // RL17
  assign low_mem_write_n = at_mem_write_n | !st_ff.low_mem;
  assign at_io_read_n    = !(st_ff.cmd_on && !st_ff.cyc.is_mem && !st_ff.cyc.is_write);
  assign at_io_write_n   = !(st_ff.cmd_on && !st_ff.cyc.is_mem && st_ff.cyc.is_write);
endmodule

/* File: rtl/at_proc_end.sv */
/*
  processor end: issues single cycles on request and grants hold.
  assumes the bridge answers through at_bridge_if on the same clock.
*/
`timescale 1ns/1ps
module at_proc_end
  import at_bridge_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  at_bridge_if.proc        pif,
  input  wire logic        req_valid,
  input  wire logic        req_mem,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_be_n,
  input  wire logic        fp_fault,
  output logic             req_ready,
  output logic             done
);
  typedef struct packed {
    logic        busy;
    logic        strobe;
    logic        held;
    logic        done;
    logic        mem;
    logic        wr;
    logic [31:0] addr;
    logic [3:0]  be_n;
  } proc_t;

  proc_t st_ff;
  proc_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe = 1'b0;
    nxt_st.done = 1'b0;
    if (!st_ff.busy) begin
      if (pif.hold_req) begin
        nxt_st.held = 1'b1; // RL4
      end else begin
        nxt_st.held = 1'b0;
        if (req_valid) begin
          nxt_st.busy = 1'b1;
          nxt_st.strobe = 1'b1; // RL1
          nxt_st.mem = req_mem;
          nxt_st.wr = req_write;
          nxt_st.addr = req_addr;
          nxt_st.be_n = req_be_n;
        end
      end
    end else if (!pif.proc_ready_n) begin
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.be_n <= 4'hF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pif.addr_strobe_n  = !st_ff.strobe;
  assign pif.m_io           = st_ff.mem;
  assign pif.w_r            = st_ff.wr;
  assign pif.d_c            = 1'b1;
  assign pif.byte_enables_n = st_ff.be_n;
  assign pif.addr_from_proc = st_ff.addr;
  assign pif.hold_ack       = st_ff.held;
  assign pif.fp_error_n     = !fp_fault; // RL9
  assign pif.burst_last_n   = 1'b0; // RL10
  assign req_ready          = !st_ff.busy && !pif.hold_req && !st_ff.held;
  assign done               = st_ff.done;
endmodule

/* File: bench/at_bridge_chk.sv */
/*
  concurrent checks on the processor-side signals of the bridge.
  assumes it sits beside the interface, all in the ref_clk domain.
*/
`timescale 1ns/1ps
module at_bridge_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic proc_ready_n,
  input wire logic burst_ready_n,
  input wire logic hold_req,
  input wire logic hold_ack,
  input wire logic addr_to_proc_oe,
  input wire logic nmi,
  input wire logic nmi_req,
  input wire logic proc_irq,
  input wire logic irq_pending,
  input wire logic addr20_mask_n,
  input wire logic a20_gate,
  input wire logic proc_reset,
  input wire logic proc_error_out_n,
  input wire logic alt_mode,
  input wire logic proc_busy_out_n,
  input wire logic copro_busy_n,
  input wire logic proc_request_out,
  input wire logic copro_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_ready_pulse: assert property (!proc_ready_n |=> proc_ready_n)
    else $error("ready held past one cycle");
  a_burst_ready: assert property (!alt_mode |-> burst_ready_n == proc_ready_n)
    else $error("burst ready differs from ready");
  a_hold_grant: assert property ($rose(hold_ack) |-> hold_req)
    else $error("acknowledge without request");
  a_hold_keep: assert property (hold_req && hold_ack |=> hold_ack)
    else $error("acknowledge dropped while requested");
  a_addr_drive: assert property (hold_req && hold_ack && $past(hold_ack, 2) |-> addr_to_proc_oe)
    else $error("address not driven while held");
  a_addr_float: assert property (!hold_req && !hold_ack |-> !addr_to_proc_oe)
    else $error("address driven outside hold");
  a_nmi_follow: assert property (nmi == nmi_req)
    else $error("nmi does not follow request");
  a_irq_follow: assert property (proc_irq == irq_pending)
    else $error("irq does not follow pending");
  a_a20_reset: assert property (proc_reset |-> addr20_mask_n)
    else $error("a20 mask active in reset");
  a_a20_gate: assert property (!proc_reset && $stable(a20_gate) |-> addr20_mask_n == a20_gate)
    else $error("a20 mask differs from gate");
  a_err_reset: assert property (!proc_error_out_n |-> proc_reset || $past(proc_reset))
    else $error("error out active after reset");
  a_busy_pass: assert property (alt_mode |-> proc_busy_out_n == $past(copro_busy_n, 2))
    else $error("busy not passed through");
  a_req_pass: assert property (alt_mode |-> proc_request_out == $past(copro_request, 2))
    else $error("request not passed through");
endmodule

/* File: bench/tb_cpu_to_at_bus_cycle_bridge.sv */
/*
  bench joining the processor end and the bridge end through the interface.
  assumes the bench drives the expansion-bus inputs and watches commands.
*/
`timescale 1ns/1ps
module tb_cpu_to_at_bus_cycle_bridge;
  import at_bridge_pkg::*;
  typedef struct packed {
    logic [8:0] pat;
    logic [1:0] how;
    logic [9:0] len;
  } note_t;
  localparam int DIVS [8] = '{int'(FIXED_DIV), 10, 8, 6, 5, 4, 3, 2};
  logic        ref_clk, sys_rst, ws16_fast, ws8_fast, alt_mode, nmi_req, irq_pending;
  logic        a20_gate, cacheable, bus_hold_req, dma_cycle, dma_wide, copro_error_n;
  logic        copro_busy_n, copro_request, local_dev_cycle_n, local_dev_ready_n;
  logic        mem_wide_sel_n, io_wide_sel_n, zero_wait_n, channel_ready, master_n;
  logic        at_addr_bit0_in, req_valid, req_mem, req_write, fp_fault, busy, wd;
  logic        at_bus_clk, at_addr_bit0, at_addr_bit1, high_byte_en_n, at_addr_oe;
  logic        at_mem_read_n, at_mem_write_n, low_mem_read_n, low_mem_write_n;
  logic        at_io_read_n, at_io_write_n, at_cmd_oe, copro_present, req_ready, done;
  logic [2:0]  at_clk_select;
  logic [3:0]  req_be_n;
  logic [31:0] hold_addr, req_addr;
  int          error_cnt, n_tests, len, base;
  note_t       q[$];
  note_t       nt;

  at_bridge_if  pif ();
  at_bridge_dev u_at_bridge_dev (.*);
  at_proc_end   u_at_proc_end (.*);
  at_bridge_chk u_at_bridge_chk (.*, .proc_ready_n(pif.proc_ready_n),
    .burst_ready_n(pif.burst_ready_n), .hold_req(pif.hold_req), .hold_ack(pif.hold_ack),
    .addr_to_proc_oe(pif.addr_to_proc_oe), .nmi(pif.nmi), .proc_irq(pif.proc_irq),
    .addr20_mask_n(pif.addr20_mask_n), .proc_reset(pif.proc_reset),
    .proc_error_out_n(pif.proc_error_out_n), .proc_busy_out_n(pif.proc_busy_out_n),
    .proc_request_out(pif.proc_request_out));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // command, low-memory and byte-lane levels expected during a cycle
  function automatic logic [8:0] expect_pat(input logic m, w, input logic [31:0] a,
                                            input logic [3:0] be_n);
    logic [3:0] b;
    logic       lo;
    b = ~be_n;
    lo = m && a[31:20] == 12'h000;
    return {!(m & !w), !(m & w), !(!m & !w), !(!m & w), !(lo & !w), !(lo & w),
            be_n[1:0] == 2'h3, !b[0] && (b[1] || !b[2]), !(b[1] | b[3])};
  endfunction

  task automatic cfg(input logic [2:0] s, input logic wide, input logic fast);
    time t0;
    at_clk_select <= s;
    {mem_wide_sel_n, io_wide_sel_n} <= {2{!wide}};
    {ws16_fast, ws8_fast} <= {2{fast}};
    {nmi_req, irq_pending, a20_gate, cacheable, alt_mode, copro_busy_n, copro_request,
     fp_fault, at_addr_bit0_in} <= 9'($urandom);
    repeat (30) @(posedge ref_clk);
    check(pif.ignore_num_err_n, alt_mode ? !copro_request : !fp_fault);
    // one full bus clock period, counted in ref_clk periods
    @(posedge at_bus_clk);
    t0 = $time;
    @(posedge at_bus_clk);
    check(32'(($time - t0) / 40), DIVS[s]);
  endtask

  // how: 0 exact length, 1 longer, 2 shorter, 3 no expansion-bus command
  task automatic at_cyc(input logic m, w, input logic [31:0] a, input logic [3:0] be,
                        input logic [1:0] how, input int lx);
    int i;
    if (how != 2'h3) q.push_back({expect_pat(m, w, a, be), how, lx[9:0]});
    @(posedge ref_clk);
    {req_valid, req_mem, req_write} <= {1'b1, m, w};
    {req_addr, req_be_n} <= {a, be};
    i = 0;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++i < 50);
    req_valid <= 1'b0;
    i = 0;
    do @(posedge ref_clk); while (done !== 1'b1 && ++i < 3000);
    check(done, 1);
    repeat (2) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      busy = 1'b0;
    end else if (!(&{at_mem_read_n, at_mem_write_n, at_io_read_n, at_io_write_n})) begin
      if (!busy) begin
        nt = q.size() ? q.pop_front() : '0;
        check({at_mem_read_n, at_mem_write_n, at_io_read_n, at_io_write_n, low_mem_read_n,
               low_mem_write_n, at_addr_bit1, at_addr_bit0, high_byte_en_n}, nt.pat);
        check(pif.proc_cache_en_n, alt_mode | !(cacheable & ~&nt.pat[8:7]));
        len = 0;
      end
      busy = 1'b1;
      len++;
    end else if (busy) begin
      busy = 1'b0;
      if (nt.how == 2'h0) check(len, nt.len);
      else if (nt.how == 2'h1) check(len > nt.len, 1);
      else check(len < nt.len, 1);
    end
  end

  initial begin
    #(40 * 40000);
    error_cnt++;
    end_sim();
  end

  initial begin
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(27));
    {ws16_fast, ws8_fast, alt_mode, nmi_req, irq_pending, a20_gate, cacheable} = '0;
    {bus_hold_req, dma_cycle, dma_wide, req_valid, req_mem, req_write, fp_fault} = '0;
    {copro_busy_n, copro_request, local_dev_cycle_n, local_dev_ready_n} = 4'hB;
    {mem_wide_sel_n, io_wide_sel_n, zero_wait_n, channel_ready, master_n} = 5'h1F;
    {at_addr_bit0_in, copro_error_n, sys_rst} = {2'($urandom), 1'b1};
    {at_clk_select, req_be_n, hold_addr, req_addr} = '0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(copro_present, !copro_error_n);
    for (int k = 0; k < 16; k++) begin
      wd = 1'($urandom);
      cfg(3'(k), wd, k[3]);
      // setup tick, wait-state ticks, then the closing ready tick
      base = (wd ? (k[3] ? WS16_FAST : WS16_SLOW) : (k[3] ? WS8_FAST : WS8_SLOW)) + 2;
      at_cyc(k[0], k[1], k[2] ? $urandom & 32'h000F_FFFF : $urandom | 32'h0010_0000,
             4'($urandom_range(14, 0)), 2'h0, base * DIVS[k % 8]);
    end
    cfg(3'h7, 1'b0, 1'b1);
    channel_ready <= 1'b0;
    fork
      at_cyc(1'b1, 1'b0, 32'h0000_1000, 4'h0, 2'h1, 40);
      begin
        repeat (60) @(posedge ref_clk);
        channel_ready <= 1'b1;
      end
    join
    cfg(3'h1, 1'b0, 1'b1);
    {channel_ready, zero_wait_n} <= 2'h0;
    repeat (4) @(posedge ref_clk);
    at_cyc(1'b0, 1'b1, 32'h0000_0080, 4'hE, 2'h2, 50);
    {channel_ready, zero_wait_n, local_dev_cycle_n} <= 3'h6;
    repeat (3) @(posedge ref_clk);
    fork
      at_cyc(1'b1, 1'b1, 32'h0200_0000, 4'h0, 2'h3, 0);
      begin
        repeat (8) @(posedge ref_clk);
        local_dev_ready_n <= 1'b0;
      end
    join
    {local_dev_cycle_n, local_dev_ready_n} <= 2'h3;
    hold_addr <= $urandom;
    bus_hold_req <= 1'b1;
    for (int i = 0; i < 50 && pif.hold_ack !== 1'b1; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    check({pif.hold_req, pif.hold_ack}, 3);
    check(pif.addr_to_proc, hold_addr);
    check(pif.addr_to_proc_oe, 1);
    bus_hold_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check({pif.hold_req, pif.hold_ack}, 0);
    master_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check({at_cmd_oe, at_addr_oe}, 0);
    check(at_addr_bit0, at_addr_bit0_in);
    master_n <= 1'b1;
    {dma_cycle, dma_wide} <= 2'h3;
    repeat (6) @(posedge ref_clk);
    check({at_cmd_oe, at_addr_oe}, 3);
    check(at_addr_bit0, 0);
    {dma_cycle, dma_wide} <= 2'h0;
    repeat (4) @(posedge ref_clk);
    check(q.size(), 0);
    end_sim();
  end
endmodule
